/* File: logic/psdbg_pkg.sv */
`default_nettype none
package psdbg_pkg;

    // ------------------------------------------------------------------
    // Register offsets in the processor status space
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_OSC_CTRL      = 8'h06;
    localparam logic [7:0] OFF_CORE_CELL     = 8'h07;
    localparam logic [7:0] OFF_CORE_WIRE     = 8'h08;
    localparam logic [7:0] OFF_PERIPH_CELL   = 8'h09;
    localparam logic [7:0] OFF_PERIPH_WIRE   = 8'h0a;
    localparam logic [7:0] OFF_RAM_SIZE      = 8'h0c;
    localparam logic [7:0] OFF_SAVED_STATUS  = 8'h10;
    localparam logic [7:0] OFF_SAVED_PC      = 8'h11;
    localparam logic [7:0] OFF_SAVED_STACK   = 8'h12;
    localparam logic [7:0] OFF_FETCH_THREAD  = 8'h13;
    localparam logic [7:0] OFF_FETCH_REG     = 8'h14;
    localparam logic [7:0] OFF_IRQ_CAUSE     = 8'h15;
    localparam logic [7:0] OFF_IRQ_PAYLOAD   = 8'h16;
    localparam logic [7:0] OFF_STOP_MASK     = 8'h18;
    localparam logic [7:0] OFF_SCRATCH       = 8'h20;
    localparam logic [7:0] OFF_BREAK_ADDR    = 8'h30;
    localparam logic [7:0] OFF_BREAK_CTRL    = 8'h40;

    localparam int N_SCRATCH   = 8;
    localparam int N_BREAK     = 4;
    localparam int N_THREAD    = 8;
    localparam int OSC_COUNT_W = 16;
    localparam int STATUS_W    = 11;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int OSC_CORE_BIT     = 1;
    localparam int OSC_PERIPH_BIT   = 0;
    localparam int CAUSE_LSB        = 0;
    localparam int CAUSE_THREAD_LSB = 8;
    localparam int CAUSE_INDEX_LSB  = 16;
    localparam int BCTRL_EN_BIT     = 0;
    localparam int BCTRL_NE_BIT     = 1;
    localparam int BCTRL_THREAD_LSB = 16;
    localparam int RAM_SIZE_LSB     = 2;
    // Bits 10,9,7,6 and 4..0 are debug-writable; bit 8 is read-only, bit 5 reserved.
    localparam logic [STATUS_W-1:0] STATUS_WR_MASK = 11'h6df;
    localparam logic [31:0]         RAM_BYTES_DEFAULT = 32'h0004_0000;

    localparam logic [2:0] CAUSE_NONE   = 3'h0;
    localparam logic [2:0] CAUSE_HOST   = 3'h1;
    localparam logic [2:0] CAUSE_DEBUG_CALL_INSTR  = 3'h2;
    localparam logic [2:0] CAUSE_IBREAK = 3'h3;
    localparam logic [2:0] CAUSE_DWATCH = 3'h4;
    localparam logic [2:0] CAUSE_RWATCH = 3'h5;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ps_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } ps_rsp_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  idx;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  cause;
        logic [7:0]  thread;
        logic [1:0]  index;
        logic [31:0] data;
    } dbg_event_t;

    typedef struct packed {
        logic                valid;
        logic [STATUS_W-1:0] status;
        logic [31:0]         pc;
        logic [31:0]         sp;
    } dbg_entry_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  thread;
        logic [31:0] pc;
    } pc_trace_t;

    typedef struct packed {
        logic [7:0] thread;
        logic [4:0] regnum;
    } fetch_sel_t;

    typedef struct packed {
        logic [N_THREAD-1:0] thread_en;
        logic                not_equal;
        logic                enable;
    } break_ctrl_t;

    typedef struct packed {
        logic [2:0]             sync;
        logic                   level;
        logic [OSC_COUNT_W-1:0] count;
    } osc_state_t;

endpackage
`default_nettype wire

/* File: logic/ring_osc_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module ring_osc_counter (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             osc_in,
    output logic [psdbg_pkg::OSC_COUNT_W-1:0]     count
);
    import psdbg_pkg::*;

    // The count has no reset; it starts from zero at power-up only.
    osc_state_t state_reg = '0;
    osc_state_t state_next;

    // ------------------------------------------------------------------
    // Edge counting of the free-running oscillator
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.sync = {state_reg.sync[1:0], osc_in};
        if (state_reg.sync[1] == state_reg.sync[2] && state_reg.sync[2] != state_reg.level) begin
            state_next.level = state_reg.sync[2];
            if (state_reg.sync[2]) begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
        if (rst) begin
            // Level follows the pin in reset, so release shows no false edge.
            state_next.level = state_reg.sync[2];
            state_next.count = state_reg.count;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    assign count = state_reg.count;

endmodule
`default_nettype wire

/* File: logic/processor_status_debug_regs.sv */
// Summary of operation
// - Control bits start core and peripheral oscillators
// - Oscillators free-run; clk samples them and counts their rising edges
// - Four read-only 16-bit counts at 0x07-0x0A
// - Oscillator counts survive system reset
// - RAM size readable at 0x0C bits 31:2
// - Saved status captured on debugger entry
// - Status bits 0-4: events, interrupts, sequence, handler, kernel
// - Status bits 6-10: paused, fast, issue modes, ASID
// - Saved PC and stack captured on entry
// - Fetch thread 7:0 and register 4:0 select
// - Debug cause code recorded in bits 2:0
// - Lowest firing breakpoint index in bits 17:16
// - Causing thread number in bits 15:8
// - Watchpoint address or resource id in payload
// - Stop mask holds threads after debug return
// - Eight scratch words shared with configuration space
// - Four breakpoint addresses raise debug interrupt
// - Breakpoint enable, inequality and per-thread bits
`timescale 1ns/100ps
`default_nettype none
module processor_status_debug_regs #(
    parameter logic [31:0] RAM_BYTES = psdbg_pkg::RAM_BYTES_DEFAULT
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire psdbg_pkg::ps_req_t      ps_req,
    output psdbg_pkg::ps_rsp_t           ps_rsp,
    input  wire psdbg_pkg::cfg_req_t     cfg_req,
    output psdbg_pkg::ps_rsp_t           cfg_rsp,
    input  wire logic                    in_debug,
    input  wire psdbg_pkg::dbg_entry_t   dbg_entry,
    input  wire psdbg_pkg::dbg_event_t   dbg_event,
    input  wire psdbg_pkg::pc_trace_t    pc_trace,
    input  wire logic [3:0]              osc_in,
    output logic [1:0]                   osc_run,
    output logic                         dbg_irq,
    output psdbg_pkg::fetch_sel_t        fetch_sel,
    output logic [7:0]                   thread_stop_mask
);
    import psdbg_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                      osc_ctrl;
        logic [STATUS_W-1:0]             status;
        logic [31:0]                     saved_program_counter;
        logic [31:0]                     saved_stack_pointer;
        logic [7:0]                      fetch_thread;
        logic [4:0]                      fetch_reg;
        logic [2:0]                      cause;
        logic [7:0]                      cause_thread;
        logic [1:0]                      cause_index;
        logic [31:0]                     payload;
        logic [7:0]                      stop_mask;
        logic [N_SCRATCH-1:0][31:0]      scratch;
        logic [N_BREAK-1:0][31:0]        break_addr;
        logic [N_BREAK-1:0]              break_en;
        logic [N_BREAK-1:0]              break_ne;
        logic [N_BREAK-1:0][N_THREAD-1:0] break_thread;
        logic                            pending;
        ps_rsp_t                         rsp;
        ps_rsp_t                         cfg_rsp;
    } regs_state_t;

    regs_state_t state_reg;
    regs_state_t state_next;

    logic [3:0][OSC_COUNT_W-1:0] osc_count;

    // ------------------------------------------------------------------
    // Oscillator counters
    // ------------------------------------------------------------------
    // Index 0 core cell, 1 core wire, 2 peripheral cell, 3 peripheral wire.
    for (genvar i = 0; i < 4; i++) begin : g_osc
        ring_osc_counter u_cnt (
            .clk    (clk),
            .rst    (rst),
            .osc_in (osc_in[i]),
            .count  (osc_count[i])
        );
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic break_fires(
        input logic [31:0]         addr,
        input logic                en,
        input logic                ne,
        input logic [N_THREAD-1:0] thr_en,
        input pc_trace_t           tr
    );
        logic equal;
        equal = (tr.pc == addr);
        break_fires = en && thr_en[tr.thread] && (equal ^ ne);
    endfunction

    function automatic logic [31:0] zext16(input logic [OSC_COUNT_W-1:0] v);
        zext16 = {{(32 - OSC_COUNT_W){1'b0}}, v};
    endfunction

    function automatic logic [31:0] read_word(input regs_state_t s,
                                              input logic [7:0] a,
                                              input logic [3:0][OSC_COUNT_W-1:0] cnt);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a[7:3] == OFF_SCRATCH[7:3]) begin
            w = s.scratch[a[2:0]];
        end else if (a[7:2] == OFF_BREAK_ADDR[7:2]) begin
            w = s.break_addr[a[1:0]];
        end else if (a[7:2] == OFF_BREAK_CTRL[7:2]) begin
            w[BCTRL_EN_BIT] = s.break_en[a[1:0]];
            w[BCTRL_NE_BIT] = s.break_ne[a[1:0]];
            w[BCTRL_THREAD_LSB +: N_THREAD] = s.break_thread[a[1:0]];
        end else begin
            unique case (a)
                OFF_OSC_CTRL:     w[1:0] = s.osc_ctrl;
                OFF_CORE_CELL:    w = zext16(cnt[0]);
                OFF_CORE_WIRE:    w = zext16(cnt[1]);
                OFF_PERIPH_CELL:  w = zext16(cnt[2]);
                OFF_PERIPH_WIRE:  w = zext16(cnt[3]);
                OFF_RAM_SIZE:     w = {RAM_BYTES[31:RAM_SIZE_LSB], 2'b00};
                OFF_SAVED_STATUS: w[STATUS_W-1:0] = s.status;
                OFF_SAVED_PC:     w = s.saved_program_counter;
                OFF_SAVED_STACK:  w = s.saved_stack_pointer;
                OFF_FETCH_THREAD: w[7:0] = s.fetch_thread;
                OFF_FETCH_REG:    w[4:0] = s.fetch_reg;
                OFF_IRQ_CAUSE: begin
                    w[CAUSE_LSB +: 3]        = s.cause;
                    w[CAUSE_THREAD_LSB +: 8] = s.cause_thread;
                    w[CAUSE_INDEX_LSB +: 2]  = s.cause_index;
                end
                OFF_IRQ_PAYLOAD:  w = s.payload;
                OFF_STOP_MASK:    w[7:0] = s.stop_mask;
                default:          w = 32'h0000_0000;
            endcase
        end
        read_word = w;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [N_BREAK-1:0] fired;
        logic [1:0]         first;
        logic               dbg_wr;
        logic               bp_hit;
        logic [7:0]         a;
        logic [31:0]        d;

        state_next = state_reg;
        fired      = '0;
        first      = 2'b00;
        bp_hit     = 1'b0;
        a          = ps_req.addr;
        d          = ps_req.wdata;
        // Debug-only fields ignore writes made outside debug mode.
        dbg_wr     = ps_req.wr && in_debug;

        // Instruction breakpoints; lowest index wins on a tie.
        for (int i = N_BREAK - 1; i >= 0; i--) begin
            fired[i] = pc_trace.valid
                       && break_fires(state_reg.break_addr[i], state_reg.break_en[i],
                                      state_reg.break_ne[i], state_reg.break_thread[i],
                                      pc_trace);
            if (fired[i]) begin
                first = 2'(i);
            end
        end
        bp_hit = |fired;

        // Reads answer one cycle after the request with a one-cycle valid.
        state_next.rsp.valid = ps_req.rd;
        state_next.rsp.data  = ps_req.rd ? read_word(state_reg, a, osc_count) : 32'h0000_0000;
        state_next.cfg_rsp.valid = cfg_req.rd;
        state_next.cfg_rsp.data  = cfg_req.rd ? state_reg.scratch[cfg_req.idx] : 32'h0000_0000;

        // Debugger side of the shared scratch words; a core write in the same
        // cycle is applied after this and so takes priority.
        if (cfg_req.wr) begin
            state_next.scratch[cfg_req.idx] = cfg_req.wdata;
        end

        // Oscillator enables are plain read-write, usable outside debug.
        if (ps_req.wr && a == OFF_OSC_CTRL) begin
            state_next.osc_ctrl[OSC_CORE_BIT]   = d[OSC_CORE_BIT];
            state_next.osc_ctrl[OSC_PERIPH_BIT] = d[OSC_PERIPH_BIT];
        end

        if (dbg_wr) begin
            if (a[7:3] == OFF_SCRATCH[7:3]) begin
                state_next.scratch[a[2:0]] = d;
            end else if (a[7:2] == OFF_BREAK_ADDR[7:2]) begin
                state_next.break_addr[a[1:0]] = d;
            end else if (a[7:2] == OFF_BREAK_CTRL[7:2]) begin
                state_next.break_en[a[1:0]]     = d[BCTRL_EN_BIT];
                state_next.break_ne[a[1:0]]     = d[BCTRL_NE_BIT];
                state_next.break_thread[a[1:0]] = d[BCTRL_THREAD_LSB +: N_THREAD];
            end else begin
                unique case (a)
                    OFF_SAVED_STATUS: begin
                        state_next.status = (state_reg.status & ~STATUS_WR_MASK)
                                            | (d[STATUS_W-1:0] & STATUS_WR_MASK);
                    end
                    OFF_SAVED_PC:     state_next.saved_program_counter = d;
                    OFF_SAVED_STACK:  state_next.saved_stack_pointer = d;
                    OFF_FETCH_THREAD: state_next.fetch_thread = d[7:0];
                    OFF_FETCH_REG:    state_next.fetch_reg = d[4:0];
                    OFF_IRQ_CAUSE: begin
                        state_next.cause        = d[CAUSE_LSB +: 3];
                        state_next.cause_thread = d[CAUSE_THREAD_LSB +: 8];
                        state_next.cause_index  = d[CAUSE_INDEX_LSB +: 2];
                    end
                    OFF_IRQ_PAYLOAD:  state_next.payload = d;
                    OFF_STOP_MASK:    state_next.stop_mask = d[7:0];
                    default: begin
                    end
                endcase
            end
        end

        // Debug interrupt recording. Only one cause is held, so new events are
        // ignored while one is pending or the core is already in debug mode.
        if (!state_reg.pending && !in_debug) begin
            if (dbg_event.valid) begin
                state_next.pending      = 1'b1;
                state_next.cause        = dbg_event.cause;
                state_next.cause_thread = 8'h00;
                state_next.cause_index  = 2'b00;
                if (dbg_event.cause != CAUSE_HOST) begin
                    state_next.cause_thread = dbg_event.thread;
                end
                if (dbg_event.cause > CAUSE_DEBUG_CALL_INSTR) begin
                    state_next.cause_index = dbg_event.index;
                end
                if (dbg_event.cause == CAUSE_DWATCH || dbg_event.cause == CAUSE_RWATCH) begin
                    state_next.payload     = dbg_event.data;
                end
            end else if (bp_hit) begin
                state_next.pending      = 1'b1;
                state_next.cause        = CAUSE_IBREAK;
                state_next.cause_thread = {5'b00000, pc_trace.thread};
                state_next.cause_index  = first;
            end
        end

        // Entry into the debugger snapshots the thread context.
        // An event taken in the same cycle keeps the flag set.
        if (dbg_entry.valid) begin
            state_next.pending = !state_reg.pending && state_next.pending;
            state_next.status  = dbg_entry.status & ~(STATUS_W'(1) << 5);
            state_next.saved_program_counter     = dbg_entry.pc;
            state_next.saved_stack_pointer     = dbg_entry.sp;
        end

        if (rst) begin
            state_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ps_rsp           = state_reg.rsp;
    assign cfg_rsp          = state_reg.cfg_rsp;
    assign osc_run          = state_reg.osc_ctrl;
    assign dbg_irq          = state_reg.pending;
    assign fetch_sel        = '{thread: state_reg.fetch_thread, regnum: state_reg.fetch_reg};
    assign thread_stop_mask = state_reg.stop_mask;

endmodule
`default_nettype wire

/* File: tb/processor_status_debug_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module processor_status_debug_regs_properties #(
    parameter logic [31:0] RAM_BYTES = 32'h0000_0000
) (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire psdbg_pkg::ps_req_t    ps_req,
    input wire psdbg_pkg::ps_rsp_t    ps_rsp,
    input wire psdbg_pkg::cfg_req_t   cfg_req,
    input wire psdbg_pkg::ps_rsp_t    cfg_rsp,
    input wire logic                  in_debug,
    input wire psdbg_pkg::dbg_entry_t dbg_entry,
    input wire psdbg_pkg::dbg_event_t dbg_event,
    input wire logic [1:0]            osc_run,
    input wire logic                  dbg_irq,
    input wire psdbg_pkg::fetch_sel_t fetch_sel,
    input wire logic [7:0]            thread_stop_mask
);
    import psdbg_pkg::*;
    // ------------------------------------------------------------------
    // Write data of the previous edge, so write effects compare to it.
    // ------------------------------------------------------------------
    logic [31:0] wdata_q;
    always_ff @(posedge clk) begin
        wdata_q <= ps_req.wdata;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_read_answer: assert property (ps_req.rd |=> ps_rsp.valid)
        else $error("status read got no answer");
    a_osc_enable: assert property (ps_req.wr && ps_req.addr == OFF_OSC_CTRL
        |=> osc_run == wdata_q[1:0]) else $error("oscillator run bits wrong");
    a_count_upper: assert property (ps_req.rd && ps_req.addr >= OFF_CORE_CELL
        && ps_req.addr <= OFF_PERIPH_WIRE |=> ps_rsp.data[31:16] == 16'h0)
        else $error("count upper bits not zero");
    a_ram_size: assert property (ps_req.rd && ps_req.addr == OFF_RAM_SIZE
        |=> ps_rsp.data == {RAM_BYTES[31:2], 2'b00}) else $error("ram size wrong");
    a_event_raises: assert property (dbg_event.valid && !dbg_irq && !in_debug
        |=> dbg_irq) else $error("debug event did not raise interrupt");
    a_entry_clears: assert property (dbg_irq && dbg_entry.valid |=> !dbg_irq)
        else $error("debugger entry did not clear interrupt");
    a_irq_holds: assert property (dbg_irq && !dbg_entry.valid |=> dbg_irq)
        else $error("debug interrupt dropped early");
    a_mask_locked: assert property (!in_debug |=> $stable(thread_stop_mask))
        else $error("stop mask changed outside debug");
    a_mask_write: assert property (ps_req.wr && in_debug && ps_req.addr == OFF_STOP_MASK
        |=> thread_stop_mask == wdata_q[7:0]) else $error("stop mask not written");
    a_fetch_thread: assert property (ps_req.wr && in_debug
        && ps_req.addr == OFF_FETCH_THREAD |=> fetch_sel.thread == wdata_q[7:0])
        else $error("fetch thread select wrong");
    a_scratch_answer: assert property (cfg_req.rd |=> cfg_rsp.valid)
        else $error("scratch read got no answer");
endmodule
bind processor_status_debug_regs processor_status_debug_regs_properties #(
    .RAM_BYTES(RAM_BYTES)
) i_props (
    .clk(clk), .rst(rst), .ps_req(ps_req), .ps_rsp(ps_rsp), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .in_debug(in_debug), .dbg_entry(dbg_entry), .dbg_event(dbg_event),
    .osc_run(osc_run), .dbg_irq(dbg_irq), .fetch_sel(fetch_sel),
    .thread_stop_mask(thread_stop_mask)
);
`default_nettype wire

/* File: tb/ring_osc_source.sv */
`timescale 1ns/100ps
`default_nettype none
module ring_osc_source (
    input wire logic [1:0] osc_run,
    output logic [3:0]     osc_in
);
    // ------------------------------------------------------------------
    // Stopped oscillators hold their level; periods share no ratio with clk.
    // ------------------------------------------------------------------
    logic c0 = 1'b0;
    logic c1 = 1'b0;
    logic p0 = 1'b0;
    logic p1 = 1'b0;
    assign osc_in = {p1, p0, c1, c0};
    always #23.3 if (osc_run[1]) c0 = ~c0;
    always #31.7 if (osc_run[1]) c1 = ~c1;
    always #41.9 if (osc_run[0]) p0 = ~p0;
    always #53.1 if (osc_run[0]) p1 = ~p1;
endmodule
`default_nettype wire

/* File: tb/processor_status_debug_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module processor_status_debug_regs_tb;
    import psdbg_pkg::*;
    localparam logic [31:0] RAM_SET = 32'h0001_2347;
    logic clk;
    logic rst;
    ps_req_t ps_req;
    ps_rsp_t ps_rsp;
    cfg_req_t cfg_req;
    ps_rsp_t cfg_rsp;
    logic in_debug;
    dbg_entry_t dbg_entry;
    dbg_event_t dbg_event;
    pc_trace_t pc_trace;
    logic [3:0] osc_in;
    logic [1:0] osc_run;
    logic dbg_irq;
    fetch_sel_t fetch_sel;
    logic [7:0] thread_stop_mask;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    processor_status_debug_regs #(.RAM_BYTES(RAM_SET)) i_dut (
        .clk(clk), .rst(rst), .ps_req(ps_req), .ps_rsp(ps_rsp), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .in_debug(in_debug), .dbg_entry(dbg_entry),
        .dbg_event(dbg_event), .pc_trace(pc_trace), .osc_in(osc_in), .osc_run(osc_run),
        .dbg_irq(dbg_irq), .fetch_sel(fetch_sel), .thread_stop_mask(thread_stop_mask)
    );
    ring_osc_source i_osc (.osc_run(osc_run), .osc_in(osc_in));
    // ------------------------------------------------------------------
    // Clock, hang guard and shared bus tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            results();
        end
    end
    task automatic results();
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ps_wr(input logic [7:0] a, input logic [31:0] d);
        ps_req.wr = 1'b1;
        ps_req.addr = a;
        ps_req.wdata = d;
        @(negedge clk);
        ps_req.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic ps_rd(input logic [7:0] a, output logic [31:0] d);
        ps_req.rd = 1'b1;
        ps_req.addr = a;
        @(negedge clk);
        ps_req.rd = 1'b0;
        d = ps_rsp.data;
        @(negedge clk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ps_rd(a, d);
        cmp($sformatf("register %h", a), exp, d);
    endtask
    task automatic enter(input logic [31:0] pc, input logic [31:0] sp);
        dbg_entry = '{1'b1, 11'h7ff, pc, sp};
        @(negedge clk);
        dbg_entry.valid = 1'b0;
        cmp("irq cleared", 32'h0, {31'h0, dbg_irq});
        chk_rd(OFF_SAVED_STATUS, 32'h0000_07df);
        chk_rd(OFF_SAVED_PC, pc);
        chk_rd(OFF_SAVED_STACK, sp);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_osc();
        logic [31:0] c0;
        logic [31:0] c1;
        chk_rd(OFF_OSC_CTRL, 32'h0);
        ps_wr(OFF_OSC_CTRL, 32'hffff_ffff);
        chk_rd(OFF_OSC_CTRL, 32'h3);
        cmp("osc run", 32'h3, {30'h0, osc_run});
        repeat (200) @(negedge clk);
        ps_wr(OFF_OSC_CTRL, 32'h0);
        repeat (10) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            ps_rd(OFF_CORE_CELL + 8'(i), c0);
            cmp("count live", 32'h1, {31'h0, c0 != 32'h0});
            cmp("count upper", 32'h0, {16'h0, c0[31:16]});
            rst = 1'b1;
            repeat (5) @(negedge clk);
            rst = 1'b0;
            @(negedge clk);
            ps_rd(OFF_CORE_CELL + 8'(i), c1);
            cmp("count after reset", c0, c1);
        end
        chk_rd(OFF_RAM_SIZE, {RAM_SET[31:2], 2'b00});
        chk_rd(8'h0b, 32'h0);
    endtask
    task automatic t_debug_regs();
        ps_wr(OFF_STOP_MASK, 32'h0000_00a5);
        chk_rd(OFF_STOP_MASK, 32'h0);
        in_debug = 1'b1;
        ps_wr(OFF_STOP_MASK, 32'hffff_ffa5);
        chk_rd(OFF_STOP_MASK, 32'h0000_00a5);
        cmp("stop mask", 32'ha5, {24'h0, thread_stop_mask});
        ps_wr(OFF_FETCH_THREAD, 32'habcd_ef12);
        ps_wr(OFF_FETCH_REG, 32'hffff_ffff);
        chk_rd(OFF_FETCH_THREAD, 32'h12);
        chk_rd(OFF_FETCH_REG, 32'h1f);
        cmp("fetch select", {19'h0, 13'h025f}, {19'h0, fetch_sel});
        in_debug = 1'b0;
    endtask
    task automatic t_scratch();
        cfg_req = '{1'b1, 1'b0, 3'h2, 32'h5a5a_0002};
        @(negedge clk);
        cfg_req.wr = 1'b0;
        chk_rd(OFF_SCRATCH + 8'h2, 32'h5a5a_0002);
        in_debug = 1'b1;
        ps_wr(OFF_SCRATCH + 8'h5, 32'hc3c3_0005);
        in_debug = 1'b0;
        cfg_req = '{1'b0, 1'b1, 3'h5, 32'h0};
        @(negedge clk);
        cfg_req.rd = 1'b0;
        cmp("cfg scratch", 32'hc3c3_0005, cfg_rsp.data);
    endtask
    task automatic t_breakpoint();
        in_debug = 1'b1;
        for (int i = 1; i < 4; i += 2) begin
            ps_wr(OFF_BREAK_ADDR + 8'(i), 32'h0000_4440);
            ps_wr(OFF_BREAK_CTRL + 8'(i), 32'h0004_0000 + 32'(i));
        end
        in_debug = 1'b0;
        pc_trace = '{1'b1, 3'h3, 32'h0000_4440};
        @(negedge clk);
        cmp("irq idle", 32'h0, {31'h0, dbg_irq});
        pc_trace = '{1'b1, 3'h2, 32'h0000_4440};
        @(negedge clk);
        pc_trace.valid = 1'b0;
        cmp("irq on break", 32'h1, {31'h0, dbg_irq});
        chk_rd(OFF_IRQ_CAUSE, 32'h0001_0203);
        enter(32'h0000_4440, 32'h0001_fff0);
        pc_trace = '{1'b1, 3'h2, 32'h0000_4444};
        @(negedge clk);
        pc_trace.valid = 1'b0;
        chk_rd(OFF_IRQ_CAUSE, 32'h0003_0203);
        enter(32'h0000_4444, 32'h0001_fff0);
    endtask
    task automatic t_events();
        logic [7:0] thr;
        logic [1:0] idx;
        for (int c = 1; c <= 5; c++) begin
            dbg_event = '{1'b1, c[2:0], 8'h05, 2'h2, 32'h0000_1000 + c};
            @(negedge clk);
            dbg_event = '{1'b1, CAUSE_HOST, 8'h07, 2'h1, 32'h0};
            @(negedge clk);
            dbg_event.valid = 1'b0;
            cmp("irq on event", 32'h1, {31'h0, dbg_irq});
            thr = (c == 1) ? 8'h00 : 8'h05;
            idx = (c < 3) ? 2'h0 : 2'h2;
            chk_rd(OFF_IRQ_CAUSE, {14'h0, idx, thr, 5'h0, c[2:0]});
            if (c > 3) chk_rd(OFF_IRQ_PAYLOAD, 32'h0000_1000 + c);
            enter(32'h8000_0000 + c, 32'h0002_0000 - c);
        end
    endtask
    initial begin
        rst = 1'b1;
        ps_req = '0;
        cfg_req = '0;
        in_debug = 1'b0;
        dbg_entry = '0;
        dbg_event = '0;
        pc_trace = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_osc();
        t_debug_regs();
        t_scratch();
        t_breakpoint();
        t_events();
        results();
    end
endmodule
`default_nettype wire
